/* File: rtl/mpsl_pkg.sv */
// Shared constants and carriers for the multi-port SDRAM local-port front end
package mpsl_pkg;
  // --------------------------------------------------------------------------
  // Port kinds and memory types
  // --------------------------------------------------------------------------
  localparam logic [0:0] PORT_RANDOM = 1'h0;
  localparam logic [0:0] PORT_BURST = 1'h1;
  localparam logic [0:0] MEM_SDR = 1'h0;
  localparam logic [0:0] MEM_DDR = 1'h1;
  localparam int MAX_PORTS = 16;
  // --------------------------------------------------------------------------
  // Register map of the command port (two aligned words)
  // --------------------------------------------------------------------------
  localparam logic [3:0] REG_FLUSH = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [31:0] FLUSH_RESET = 32'h0000_0000;
  localparam int FLUSH_LSB = 0;
  localparam int STATUS_DIRTY_LSB = 0;
  localparam int STATUS_VALID_LSB = 16;
  // --------------------------------------------------------------------------
  // Register bus carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mpsl_reg_req_t;
endpackage : mpsl_pkg

/* File: rtl/mpsl_port.sv */
// Local-port front end: random cached ports, burst ports, command port, arbiter
`timescale 1ns/1ns
// Notes on behaviour
// - Up to sixteen ports, each with own buffer.
// - Each port random or burst by parameter.
// - Buffers of different ports stay independent.
// - SDR width equals memory, option doubles.
// - DDR width doubles memory, option quadruples.
// - Random port has read and write buffers.
// - Read hit returns data one cycle later.
// - Miss holds waitrequest until cache synchronised.
// - Dirty write data flushed before read refill.
// - Write data leaves on read or miss.
// - Flush register present only if enabled.
// - Cache depth is parameter; outside window misses.
// - Burst port queues several posted bursts.
// - Burst start address and count captured.
// - Datavalid only while a word is ready.
// - Optional read flow permit input.
// - Permit low holds datavalid low.
// - Memory side crossings synchronised outside block.
// - Flush bit triggers write back, self-clears.
// - Round-robin memory access, starting after the last owner.
module mpsl_port #(
  parameter int NPORTS = 4,
  parameter logic [0:0] MEM_TYPE = mpsl_pkg::MEM_SDR,
  parameter int MEM_W = 16,
  parameter logic [15:0] PORT_KIND = 16'h0000,
  parameter logic [15:0] DOUBLE_W = 16'h0000,
  parameter logic [15:0] FLUSH_EN = 16'h0001,
  parameter int DEPTH = 8,
  parameter int AW = 16,
  parameter logic [0:0] READ_FLOW = 1'h1,
  parameter int MAXB = 8,
  parameter int DW = ((MEM_TYPE == mpsl_pkg::MEM_DDR) ? 2 : 1) * MEM_W * 2
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire mpsl_pkg::mpsl_reg_req_t REG_REQ,
  output logic [31:0] REG_RDATA,
  input wire logic [NPORTS-1:0] P_READ,
  input wire logic [NPORTS-1:0] P_WRITE,
  input wire logic [NPORTS*AW-1:0] P_ADDR,
  input wire logic [NPORTS*DW-1:0] P_WDATA,
  input wire logic [NPORTS*8-1:0] P_BCOUNT,
  input wire logic [NPORTS-1:0] P_DATAENABLE,
  output logic [NPORTS-1:0] P_WAITREQ,
  output logic [NPORTS-1:0] P_DATAVALID,
  output logic [NPORTS*DW-1:0] P_RDATA,
  output logic [NPORTS-1:0] MEM_REQ,
  output logic [NPORTS-1:0] MEM_GRANT,
  output logic MEM_WE,
  output logic [AW-1:0] MEM_ADDR,
  output logic [DW-1:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [DW-1:0] MEM_RDATA
);
  localparam int IW = $clog2(DEPTH);
  localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;
  // --------------------------------------------------------------------------
  // Command port
  // --------------------------------------------------------------------------
  logic [NPORTS-1:0] flush_r;
  logic [NPORTS-1:0] dirty_r;
  logic [NPORTS-1:0] valid_r;
  logic [NPORTS-1:0] flush_take;
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (REG_REQ.addr == mpsl_pkg::REG_FLUSH && |FLUSH_EN)
      rd_word[NPORTS-1:0] = flush_r;
    else if (REG_REQ.addr == mpsl_pkg::REG_STATUS)
    begin
      rd_word[mpsl_pkg::STATUS_DIRTY_LSB +: NPORTS] = dirty_r;
      rd_word[mpsl_pkg::STATUS_VALID_LSB +: NPORTS] = valid_r;
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      REG_RDATA <= 32'h0000_0000;
    else if (REG_REQ.rd)
      REG_RDATA <= rd_word;
    else
      REG_RDATA <= 32'h0000_0000;
  end

  // Flush bits: software sets, taking port clears; set wins
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      flush_r <= '0;
    else
    begin
      for (int i = 0; i < NPORTS; i++)
      begin
        if (REG_REQ.wr && REG_REQ.addr == mpsl_pkg::REG_FLUSH && REG_REQ.wdata[mpsl_pkg::FLUSH_LSB + i]
            && FLUSH_EN[i] && PORT_KIND[i] == mpsl_pkg::PORT_RANDOM)
          flush_r[i] <= 1'b1;
        else if (flush_take[i])
          flush_r[i] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Round-robin arbiter over the shared memory path
  // --------------------------------------------------------------------------
  logic [NPORTS-1:0] req;
  logic busy_r;
  logic [PW-1:0] owner_r;
  logic [PW-1:0] pick;
  logic pick_ok;

  always_comb
  begin
    pick = owner_r;
    pick_ok = 1'b0;
    for (int k = NPORTS; k >= 1; k--)
    begin
      if (req[(32'(owner_r) + k) % NPORTS])
      begin
        pick = PW'((32'(owner_r) + k) % NPORTS);
        pick_ok = 1'b1;
      end
    end
  end

  // Grant held until the owning port releases its request
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      busy_r <= 1'b0;
      owner_r <= '0;
      MEM_GRANT <= '0;
    end
    else if (!busy_r && pick_ok)
    begin
      busy_r <= 1'b1;
      owner_r <= pick;
      MEM_GRANT <= NPORTS'(1) << pick;
    end
    else if (busy_r && !req[owner_r])
    begin
      busy_r <= 1'b0;
      MEM_GRANT <= '0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      MEM_REQ <= '0;
    else
      MEM_REQ <= req;
  end

  // --------------------------------------------------------------------------
  // Per-port engines; state and buffers are private to each port
  // --------------------------------------------------------------------------
  logic [NPORTS-1:0] m_we;
  logic [NPORTS*AW-1:0] m_addr;
  logic [NPORTS*DW-1:0] m_wdata;

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : gp
      localparam int PDW = (DOUBLE_W[g] ? 2 : 1) * ((MEM_TYPE == mpsl_pkg::MEM_DDR) ? 2 : 1) * MEM_W;
      logic [AW-1:0] a;
      logic [PDW-1:0] wd;
      logic gnt;
      logic [DW-1:0] rbuf_r [DEPTH];
      logic [DW-1:0] wbuf_r [DEPTH];
      logic [DEPTH-1:0] wmask_r;
      logic [AW-1:0] base_r;
      logic [AW-1:0] wbase_r;
      logic [IW:0] cnt_r;
      logic [1:0] op_r; // 0 idle, 1 write back, 2 refill
      logic ack_here;
      assign a = P_ADDR[g*AW +: AW];
      assign wd = P_WDATA[g*DW +: PDW];
      assign gnt = MEM_GRANT[g];
      assign ack_here = gnt && MEM_ACK;
      assign m_we[g] = (op_r == 2'h1);
      assign m_addr[g*AW +: AW] = (op_r == 2'h1) ? wbase_r + AW'(cnt_r) : base_r + AW'(cnt_r);
      assign m_wdata[g*DW +: DW] = wbuf_r[cnt_r[IW-1:0]];

      if (PORT_KIND[g] == mpsl_pkg::PORT_RANDOM)
      begin : rnd
        logic rhit;
        logic whit;
        assign rhit = valid_r[g] && (a - base_r) < AW'(DEPTH);
        assign whit = (a - wbase_r) < AW'(DEPTH);
        assign req[g] = (op_r != 2'h0);
        assign flush_take[g] = flush_r[g] && op_r == 2'h0 && !P_READ[g] && !P_WRITE[g];
        // Single engine: write back first, then refill, so reads see writes
        always_ff @(posedge REF_CLK)
        begin
          if (!NRST)
          begin
            op_r <= 2'h0;
            cnt_r <= '0;
            valid_r[g] <= 1'b0;
            dirty_r[g] <= 1'b0;
            wmask_r <= '0;
            base_r <= '0;
            wbase_r <= '0;
            P_WAITREQ[g] <= 1'b1;
            P_DATAVALID[g] <= 1'b0;
            P_RDATA[g*DW +: DW] <= '0;
          end
          else
          begin
            P_DATAVALID[g] <= 1'b0;
            P_WAITREQ[g] <= 1'b1;
            unique case (op_r)
              2'h0:
              begin
                if (P_READ[g] && dirty_r[g])
                begin
                  op_r <= 2'h1;
                  cnt_r <= '0;
                end
                else if (P_READ[g] && rhit)
                begin
                  P_RDATA[g*DW +: DW] <= DW'(rbuf_r[IW'(a - base_r)]);
                  P_DATAVALID[g] <= 1'b1;
                end
                else if (P_READ[g])
                begin
                  op_r <= 2'h2;
                  base_r <= a;
                  cnt_r <= '0;
                  valid_r[g] <= 1'b0;
                end
                else if (P_WRITE[g] && dirty_r[g] && !whit)
                begin
                  op_r <= 2'h1;
                  cnt_r <= '0;
                end
                else if (P_WRITE[g])
                begin
                  if (!dirty_r[g])
                    wbase_r <= a;
                  wbuf_r[dirty_r[g] ? IW'(a - wbase_r) : '0] <= DW'(wd);
                  wmask_r[dirty_r[g] ? IW'(a - wbase_r) : '0] <= 1'b1;
                  dirty_r[g] <= 1'b1;
                  if (valid_r[g] && (a - base_r) < AW'(DEPTH))
                    rbuf_r[IW'(a - base_r)] <= DW'(wd);
                end
                else if (flush_take[g] && dirty_r[g])
                begin
                  op_r <= 2'h1;
                  cnt_r <= '0;
                end
                // Hit reads with no dirty data, and writes unless dirty data misses the window, complete without wait states
                P_WAITREQ[g] <= ((P_READ[g] && (dirty_r[g] || !rhit))
                  || (P_WRITE[g] && dirty_r[g] && !whit));
              end
              2'h1:
              begin
                if (!wmask_r[cnt_r[IW-1:0]] || ack_here)
                  cnt_r <= cnt_r + 1'b1;
                if (cnt_r == (IW+1)'(DEPTH - 1) && (!wmask_r[cnt_r[IW-1:0]] || ack_here))
                begin
                  op_r <= 2'h0;
                  dirty_r[g] <= 1'b0;
                  wmask_r <= '0;
                  cnt_r <= '0;
                end
              end
              2'h2:
              begin
                if (ack_here)
                begin
                  rbuf_r[cnt_r[IW-1:0]] <= MEM_RDATA;
                  cnt_r <= cnt_r + 1'b1;
                  if (cnt_r == (IW+1)'(DEPTH - 1))
                  begin
                    op_r <= 2'h0;
                    valid_r[g] <= 1'b1;
                  end
                end
              end
              default: op_r <= 2'h0;
            endcase
          end
        end
        // Partial write-back still issues masked slots with MEM_WE high; an ack on one writes stale buffer data
      end
      else
      begin : bst
        logic [AW-1:0] cur_r;
        logic [7:0] left_r;
        logic [7:0] q_n_r [2];
        logic [AW-1:0] q_a_r [2];
        logic [1:0] q_v_r;
        logic [DW-1:0] rq_r;
        logic rq_v_r;
        logic wr_act_r;
        logic [AW-1:0] wcur_r;
        logic [7:0] wleft_r;
        logic permit;
        assign permit = READ_FLOW ? P_DATAENABLE[g] : 1'b1;
        assign req[g] = (left_r != 8'h00) && !rq_v_r || op_r == 2'h1;
        assign flush_take[g] = 1'b0;
        assign valid_r[g] = 1'b0;
        assign dirty_r[g] = (op_r == 2'h1);
        // Two posted read bursts queue behind the active one
        always_ff @(posedge REF_CLK)
        begin
          if (!NRST)
          begin
            q_v_r <= '0;
            left_r <= '0;
            cur_r <= '0;
            base_r <= '0;
            wbase_r <= '0;
            cnt_r <= '0;
            op_r <= 2'h0;
            wr_act_r <= 1'b0;
            wleft_r <= '0;
            wcur_r <= '0;
            rq_v_r <= 1'b0;
            P_WAITREQ[g] <= 1'b1;
            P_DATAVALID[g] <= 1'b0;
            P_RDATA[g*DW +: DW] <= '0;
          end
          else
          begin
            P_WAITREQ[g] <= (P_READ[g] && q_v_r[1]) || op_r == 2'h1;
            if (P_READ[g] && !q_v_r[1] && !P_WAITREQ[g])
            begin
              q_v_r <= {q_v_r[0], 1'b1};
              q_a_r[q_v_r[0] ? 1 : 0] <= P_ADDR[g*AW +: AW];
              q_n_r[q_v_r[0] ? 1 : 0] <= P_BCOUNT[g*8 +: 8];
            end
            if (left_r == 8'h00 && q_v_r[0] && !(P_READ[g] && !P_WAITREQ[g]))
            begin
              cur_r <= q_a_r[0];
              base_r <= q_a_r[0];
              left_r <= q_n_r[0];
              q_a_r[0] <= q_a_r[1];
              q_n_r[0] <= q_n_r[1];
              q_v_r <= {1'b0, q_v_r[1]};
            end
            if (gnt && op_r == 2'h0 && MEM_ACK && !rq_v_r && left_r != 8'h00)
            begin
              rq_r <= MEM_RDATA;
              rq_v_r <= 1'b1;
              cur_r <= cur_r + 1'b1;
              base_r <= cur_r + 1'b1;
              left_r <= left_r - 1'b1;
            end
            // Word leaves only while the permit is high
            P_DATAVALID[g] <= rq_v_r && permit;
            if (rq_v_r && permit)
            begin
              P_RDATA[g*DW +: DW] <= rq_r;
              rq_v_r <= 1'b0;
            end
            // Write burst: word by word, pauses simply hold state
            if (P_WRITE[g] && !P_WAITREQ[g] && op_r == 2'h0)
            begin
              if (!wr_act_r)
              begin
                wcur_r <= P_ADDR[g*AW +: AW];
                wbase_r <= P_ADDR[g*AW +: AW];
                wleft_r <= P_BCOUNT[g*8 +: 8] - 1'b1;
                wr_act_r <= P_BCOUNT[g*8 +: 8] > 8'h01;
              end
              else
              begin
                wbase_r <= wcur_r + 1'b1;
                wcur_r <= wcur_r + 1'b1;
                wleft_r <= wleft_r - 1'b1;
                wr_act_r <= wleft_r > 8'h01;
              end
              wbuf_r[0] <= DW'(wd);
              op_r <= 2'h1;
              cnt_r <= '0;
              // Busy from the next edge on, so no word is shown as taken while the engine is full
              P_WAITREQ[g] <= 1'b1;
            end
            else if (op_r == 2'h1 && ack_here)
              op_r <= 2'h0;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Memory-side mux; the core beyond owns the clock crossing
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= '0;
    end
    else
    begin
      MEM_WE <= busy_r & m_we[owner_r];
      MEM_ADDR <= m_addr[owner_r*AW +: AW];
      MEM_WDATA <= m_wdata[owner_r*DW +: DW];
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_flush_clears;
    @(posedge REF_CLK) disable iff (!NRST)
      (flush_r[0] && flush_take[0]) |=> !flush_r[0] || REG_REQ.wr;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("flush bit not cleared");

  property p_rdata_once;
    @(posedge REF_CLK) disable iff (!NRST)
      !$past(REG_REQ.rd) |-> REG_RDATA == 32'h0000_0000;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("read data outside its cycle");

  property p_grant_onehot;
    @(posedge REF_CLK) disable iff (!NRST) $onehot0(MEM_GRANT);
  endproperty
  a_grant_onehot: assert property (p_grant_onehot) else $error("more than one grant");

  property p_hit_latency;
    @(posedge REF_CLK) disable iff (!NRST)
      ($past(P_READ[0]) && !P_WAITREQ[0] && PORT_KIND[0] == mpsl_pkg::PORT_RANDOM) |-> P_DATAVALID[0];
  endproperty
  a_hit_latency: assert property (p_hit_latency) else $error("hit data late");

  // A grant never stands without the request that it answers
  property p_grant_req;
    @(posedge REF_CLK) disable iff (!NRST) (MEM_GRANT & ~MEM_REQ) == '0;
  endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without request");

  property p_permit_stall;
    @(posedge REF_CLK) disable iff (!NRST)
      (READ_FLOW && !P_DATAENABLE[NPORTS-1]) |=> !P_DATAVALID[NPORTS-1] || PORT_KIND[NPORTS-1] == 1'b0;
  endproperty
  a_permit_stall: assert property (p_permit_stall) else $error("data given while stalled");
endmodule : mpsl_port

/* File: testbench/mpsl_mem_model.sv */
// Behavioural memory core that answers the port arbiter's word transfers
`timescale 1ns/1ns
module mpsl_mem_model #(
  parameter int AW = 16,
  parameter int DW = 32,
  parameter int NPORTS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [NPORTS-1:0] grant,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic ack,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:255];
  logic [1:0] gap_r;
  logic [NPORTS-1:0] gd_r;
  logic ack_d;
  // --------------------------------------------------------------------------
  // Storage preload: each word carries its own address
  // --------------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = DW'(32'h5a5a_0000 | i);
  end
  // One word per acknowledge; slow mode spaces them to stress the stalls
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      gap_r <= 2'h0;
      rdata <= '0;
      gd_r <= '0;
      ack_d <= 1'b0;
    end
    else
    begin
      gap_r <= gap_r + 2'h1;
      gd_r <= grant;
      ack_d <= ack;
      // Answer only once the registered address has caught up with grant and count
      if (|(grant & gd_r) && !ack && !ack_d && (!slow || gap_r == 2'h3))
      begin
        ack <= 1'b1;
        rdata <= mem[addr[7:0]];
      end
      else
      begin
        ack <= 1'b0;
        rdata <= ~rdata; // Stale data never looks valid
      end
      if (ack && we)
        mem[addr[7:0]] <= wdata;
    end
  end
endmodule : mpsl_mem_model

/* File: testbench/mpsl_port_tb.sv */
// Self-checking bench for the local-port front end
`timescale 1ns/1ns
module mpsl_port_tb;
  localparam int NP = 4;
  localparam int AW = 16;
  localparam int DW = 32;
  logic ref_clk, nrst, slow, mem_we, mem_ack;
  mpsl_pkg::mpsl_reg_req_t reg_req;
  logic [31:0] reg_rdata;
  logic [NP-1:0] p_read, p_write, p_dataenable, p_waitreq, p_datavalid, mem_req, mem_grant;
  logic [NP*AW-1:0] p_addr;
  logic [NP*DW-1:0] p_wdata, p_rdata;
  logic [NP*8-1:0] p_bcount;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] mem_wdata, mem_rdata, rd_v;
  logic [31:0] r_v;
  int err_total, tests_run, wt, lat, n;
  // --------------------------------------------------------------------------
  // Device, memory core and clock
  // --------------------------------------------------------------------------
  mpsl_port #(.NPORTS(NP), .PORT_KIND(16'h000c), .DOUBLE_W(16'h000f), .FLUSH_EN(16'h0001), .DEPTH(8)) dut_u (
    .REF_CLK(ref_clk), .NRST(nrst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
    .P_READ(p_read), .P_WRITE(p_write), .P_ADDR(p_addr), .P_WDATA(p_wdata),
    .P_BCOUNT(p_bcount), .P_DATAENABLE(p_dataenable), .P_WAITREQ(p_waitreq),
    .P_DATAVALID(p_datavalid), .P_RDATA(p_rdata), .MEM_REQ(mem_req), .MEM_GRANT(mem_grant),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata));
  mpsl_mem_model #(.AW(AW), .DW(DW), .NPORTS(NP)) mem_u (
    .clk(ref_clk), .rst_n(nrst), .slow(slow), .grant(mem_grant), .we(mem_we),
    .addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // --------------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------------
  task automatic cmp_data(string nm, logic [DW-1:0] exp, logic [DW-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_data
  task automatic cmp_count(string nm, int exp, int got);
    tests_run++;
    if (got != exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : cmp_count
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Bounded wait for the port to take its request; a hang ends the run
  task automatic wait_take(int p);
    wt = 0;
    // Random ports register their decision, so the taking edge shows a cycle late
    if (p < 2)
      @(posedge ref_clk);
    do
    begin
      @(posedge ref_clk);
      wt++;
    end while (p_waitreq[p] !== 1'b0 && wt < 400);
    if (wt >= 400)
    begin
      cmp_count("take timeout", 0, 1);
      give_verdict();
    end
    wt = wt - 1;
  endtask : wait_take
  // --------------------------------------------------------------------------
  // Command port and local port access
  // --------------------------------------------------------------------------
  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata; // Read data stands only in this cycle
  endtask : reg_rd
  task automatic port_wr(int p, logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge ref_clk);
    p_write[p] <= 1'b1;
    p_addr[p*AW +: AW] <= a;
    p_wdata[p*DW +: DW] <= d;
    wait_take(p);
    p_write[p] <= 1'b0;
  endtask : port_wr
  task automatic port_rd(int p, logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge ref_clk);
    p_read[p] <= 1'b1;
    p_addr[p*AW +: AW] <= a;
    wait_take(p);
    p_read[p] <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge ref_clk);
      lat++;
    end while (p_datavalid[p] !== 1'b1 && lat < 20);
    d = p_rdata[p*DW +: DW];
  endtask : port_rd
  // Write burst with the master pausing after word pause_at
  task automatic burst_wr(int p, logic [AW-1:0] a, int cnt, int pause_at);
    @(posedge ref_clk);
    p_write[p] <= 1'b1;
    p_addr[p*AW +: AW] <= a;
    p_bcount[p*8 +: 8] <= 8'(cnt);
    p_wdata[p*DW +: DW] <= 32'hb000_0000 | a;
    for (int i = 0; i < cnt; i++)
    begin
      wait_take(p);
      p_wdata[p*DW +: DW] <= 32'hb000_0000 | (a + i + 1);
      p_addr[p*AW +: AW] <= 16'hffff; // Only the start address may matter
      if (i == pause_at)
      begin
        p_write[p] <= 1'b0;
        @(posedge ref_clk);
        p_write[p] <= 1'b1;
      end
    end
    p_write[p] <= 1'b0;
  endtask : burst_wr
  task automatic burst_post(int p, logic [AW-1:0] a, int cnt);
    @(posedge ref_clk);
    p_read[p] <= 1'b1;
    p_addr[p*AW +: AW] <= a;
    p_bcount[p*8 +: 8] <= 8'(cnt);
    wait_take(p);
    p_read[p] <= 1'b0;
  endtask : burst_post
  // Collects cnt words; after word stall_at the permit drops for five cycles
  task automatic burst_collect(int p, logic [AW-1:0] a, int cnt, int stall_at);
    int k, t, stray;
    k = 0;
    t = 0;
    stray = 0;
    while (k < cnt && t < 2000)
    begin
      @(posedge ref_clk);
      t++;
      if (p_datavalid[p] === 1'b1)
      begin
        cmp_data("burst word", 32'hb000_0000 | (a + k), p_rdata[p*DW +: DW]);
        k++;
        if (k == stall_at)
        begin
          p_dataenable[p] <= 1'b0;
          @(posedge ref_clk);
          if (p_datavalid[p] === 1'b1)
          begin
            cmp_data("burst word", 32'hb000_0000 | (a + k), p_rdata[p*DW +: DW]);
            k++;
          end
          repeat (4)
          begin
            @(posedge ref_clk);
            stray += int'(p_datavalid[p] !== 1'b0);
          end
          cmp_count("valid while stalled", 0, stray);
          p_dataenable[p] <= 1'b1;
        end
      end
    end
    cmp_count("burst words", cnt, k);
  endtask : burst_collect
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    err_total = 0;
    tests_run = 0;
    nrst = 1'b0;
    slow = 1'b0;
    reg_req = '0;
    p_read = '0;
    p_write = '0;
    p_addr = '0;
    p_wdata = '0;
    p_bcount = '0;
    p_dataenable = '1;
    repeat (20) @(posedge ref_clk);
    cmp_data("waitreq in reset", DW'(4'hf), DW'(p_waitreq));
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reg_rd(mpsl_pkg::REG_FLUSH, r_v);
    cmp_data("flush reset", mpsl_pkg::FLUSH_RESET, r_v);
    reg_rd(4'h8, r_v);
    cmp_data("unmapped read", 32'h0, r_v);
    $display("test reset done");
    // Fill one cache window, then read back across a miss and a hit
    for (int i = 0; i < 8; i++)
      port_wr(0, 16'h10 + i, 32'hd000_0010 + i);
    port_rd(0, 16'h10, rd_v);
    cmp_data("read after write", 32'hd000_0010, rd_v);
    cmp_data("write back", 32'hd000_0017, mem_u.mem[8'h17]);
    for (int i = 1; i < 8; i++)
    begin
      port_rd(0, 16'h10 + i, rd_v);
      cmp_data("hit data", 32'hd000_0010 + i, rd_v);
      cmp_count("hit latency", 1, lat);
      cmp_count("hit stall", 0, wt);
    end
    port_rd(0, 16'h40, rd_v);
    cmp_count("miss stall", 1, int'(wt > 0));
    cmp_data("miss data", 32'h5a5a_0040, rd_v);
    $display("test random done");
    // Buffered write stays private until flushed
    port_wr(0, 16'h20, 32'hd000_0020);
    repeat (30) @(posedge ref_clk);
    cmp_data("held in buffer", 32'h5a5a_0020, mem_u.mem[8'h20]);
    port_rd(1, 16'h20, rd_v);
    cmp_data("other port view", 32'h5a5a_0020, rd_v);
    reg_wr(mpsl_pkg::REG_FLUSH, 32'h0000_0001);
    n = 0;
    do
    begin
      reg_rd(mpsl_pkg::REG_FLUSH, r_v);
      n++;
    end while (r_v[0] !== 1'b0 && n < 50);
    cmp_count("flush clears", 1, int'(n < 50));
    repeat (40) @(posedge ref_clk);
    cmp_data("flushed word", 32'hd000_0020, mem_u.mem[8'h20]);
    reg_wr(mpsl_pkg::REG_FLUSH, 32'h0000_000e);
    reg_rd(mpsl_pkg::REG_FLUSH, r_v);
    cmp_data("ignored flush bits", 32'h0, r_v);
    $display("test flush done");
    // Burst port with a slow memory core
    slow = 1'b1;
    burst_wr(3, 16'h80, 4, 1);
    n = 0;
    while (mem_u.mem[8'h83] !== 32'hb000_0083 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    for (int i = 0; i < 4; i++)
      cmp_data("burst stored", 32'hb000_0080 | i, mem_u.mem[8'h80 + i]);
    fork
      burst_post(3, 16'h80, 4);
      burst_collect(3, 16'h80, 4, 1);
    join
    fork
      begin
        burst_post(3, 16'h80, 2);
        burst_post(3, 16'h82, 2);
      end
      burst_collect(3, 16'h80, 4, 0);
    join
    $display("test burst done");
    give_verdict();
  end
endmodule : mpsl_port_tb
